//--- hdl/pmrm_phy_ctrl.sv
// Per-PHY basic control register with mirrored serial-port bits.
`timescale 1ns/1ns
module pmrm_phy_ctrl
	import pmrm_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic mgmt_we,
	input wire logic [15:0] mgmt_wdata,
	input wire logic ser_we_loop,
	input wire logic ser_we_an,
	input wire logic ser_we_xo,
	input wire logic [7:0] ser_wdata,
	output pmrm_phy_ctrl_t ctrl,
	output logic [15:0] ctrl_word
);

	typedef struct packed {
		pmrm_phy_ctrl_t c;
	} pmrm_ctrl_state_t;

	pmrm_ctrl_state_t state;
	pmrm_ctrl_state_t next_state;

	always_comb
	begin
		next_state = state;
		if (mgmt_we)
		begin
			next_state.c.loopback = mgmt_wdata[PMRM_B_LOOPBACK];
			next_state.c.speed100 = mgmt_wdata[PMRM_B_SPEED100];
			next_state.c.autoneg_on = mgmt_wdata[PMRM_B_AUTONEG_ON];
			next_state.c.power_down = mgmt_wdata[PMRM_B_POWER_DOWN];
			next_state.c.autoneg_redo =
				mgmt_wdata[PMRM_B_AUTONEG_REDO];
			next_state.c.full_duplex = mgmt_wdata[PMRM_B_FULL_DUPLEX];
			next_state.c.crossover_style_select =
				mgmt_wdata[PMRM_B_CROSSOVER];
			next_state.c.force_straight_pairing =
				mgmt_wdata[PMRM_B_STRAIGHT];
		end
		// The serial ports reach the same flops through another map.
		if (ser_we_loop)
		begin
			next_state.c.loopback = ser_wdata[PMRM_M_LOOPBACK];
			next_state.c.force_straight_pairing = ser_wdata[PMRM_M_STRAIGHT];
			next_state.c.power_down = ser_wdata[PMRM_M_POWER_DOWN];
			next_state.c.autoneg_redo = ser_wdata[PMRM_M_AUTONEG_REDO];
		end
		if (ser_we_an)
		begin
			next_state.c.autoneg_on = ser_wdata[PMRM_M_AUTONEG_ON];
			next_state.c.speed100 = ser_wdata[PMRM_M_SPEED100];
			next_state.c.full_duplex = ser_wdata[PMRM_M_FULL_DUPLEX];
		end
		if (ser_we_xo)
			next_state.c.crossover_style_select = ser_wdata[PMRM_M_CROSSOVER];
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			state <= '{c: '{loopback: 1'b0, speed100: 1'b0, autoneg_on: 1'b1,
				power_down: 1'b0, autoneg_redo: 1'b0, full_duplex: 1'b0,
				crossover_style_select: 1'b1, force_straight_pairing: 1'b0}};
		else
			state <= next_state;
	end

	assign ctrl = state.c;

	// Unsupported bits are hard zero through the write mask.
	always_comb
	begin
		ctrl_word = 16'h0000;
		ctrl_word[PMRM_B_LOOPBACK] = state.c.loopback;
		ctrl_word[PMRM_B_SPEED100] = state.c.speed100;
		ctrl_word[PMRM_B_AUTONEG_ON] = state.c.autoneg_on;
		ctrl_word[PMRM_B_POWER_DOWN] = state.c.power_down;
		ctrl_word[PMRM_B_AUTONEG_REDO] = state.c.autoneg_redo;
		ctrl_word[PMRM_B_FULL_DUPLEX] = state.c.full_duplex;
		ctrl_word[PMRM_B_CROSSOVER] = state.c.crossover_style_select;
		ctrl_word[PMRM_B_STRAIGHT] = state.c.force_straight_pairing;
		ctrl_word = ctrl_word & PMRM_CTRL_WMASK;
	end

endmodule // pmrm_phy_ctrl

//--- hdl/pmrm_pkg.sv
// Package of constants and types for the PHY management register map.
package pmrm_pkg;

	// ---------------------------------------------------------------
	// Addresses
	// ---------------------------------------------------------------
	localparam logic [4:0] PMRM_PHY1_ADDR_RST = 5'h01;
	localparam logic [4:0] PMRM_PHY2_ADDR_RST = 5'h02;
	localparam logic [7:0] PMRM_GLOBAL_CTRL_ADDR = 8'h0F;
	localparam int PMRM_GADDR_LSB = 3;
	localparam int PMRM_GADDR_MSB = 7;
	localparam logic [7:0] PMRM_LOOP1_ADDR = 8'h1D;
	localparam logic [7:0] PMRM_LOOP2_ADDR = 8'h2D;
	localparam logic [7:0] PMRM_AN1_ADDR = 8'h1C;
	localparam logic [7:0] PMRM_AN2_ADDR = 8'h2C;
	localparam logic [7:0] PMRM_XO1_ADDR = 8'h1F;
	localparam logic [7:0] PMRM_XO2_ADDR = 8'h2F;

	localparam logic [4:0] PMRM_REG_CONTROL = 5'h00;
	localparam logic [4:0] PMRM_REG_STATUS = 5'h01;
	localparam logic [4:0] PMRM_REG_ID_HIGH = 5'h02;
	localparam logic [4:0] PMRM_REG_ID_LOW = 5'h03;
	localparam logic [4:0] PMRM_REG_ADVERT = 5'h04;
	localparam logic [4:0] PMRM_REG_PARTNER = 5'h05;
	localparam logic [4:0] PMRM_REG_CABLE_DIAG = 5'h1D;
	localparam logic [4:0] PMRM_REG_SPECIAL = 5'h1F;

	// ---------------------------------------------------------------
	// Basic control field positions
	// ---------------------------------------------------------------
	localparam int PMRM_B_LOOPBACK = 14;
	localparam int PMRM_B_SPEED100 = 13;
	localparam int PMRM_B_AUTONEG_ON = 12;
	localparam int PMRM_B_POWER_DOWN = 11;
	localparam int PMRM_B_AUTONEG_REDO = 9;
	localparam int PMRM_B_FULL_DUPLEX = 8;
	localparam int PMRM_B_CROSSOVER = 5;
	localparam int PMRM_B_STRAIGHT = 4;
	// Mirror bit positions in the global byte registers.
	localparam int PMRM_M_LOOPBACK = 0;
	localparam int PMRM_M_STRAIGHT = 1;
	localparam int PMRM_M_POWER_DOWN = 3;
	localparam int PMRM_M_AUTONEG_REDO = 5;
	localparam int PMRM_M_FULL_DUPLEX = 5;
	localparam int PMRM_M_SPEED100 = 6;
	localparam int PMRM_M_AUTONEG_ON = 7;
	localparam int PMRM_M_CROSSOVER = 7;

	// Writable bits of basic control; 15, 10, 7, 6 and 3:0 are never stored.
	localparam logic [15:0] PMRM_CTRL_WMASK = 16'h7B30;
	localparam logic [15:0] PMRM_CTRL_RST = 16'h1020;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic loopback;
		logic speed100;
		logic autoneg_on;
		logic power_down;
		logic autoneg_redo;
		logic full_duplex;
		logic crossover_style_select;
		logic force_straight_pairing;
	} pmrm_phy_ctrl_t;

	typedef struct packed {
		logic req;
		logic write;
		logic [4:0] phy_addr;
		logic [4:0] reg_addr;
		logic [15:0] wdata;
	} pmrm_mgmt_req_t;

	typedef struct packed {
		logic ack;
		logic supported;
		logic [15:0] rdata;
	} pmrm_mgmt_rsp_t;

	typedef struct packed {
		logic req;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pmrm_serial_req_t;

endpackage

//--- hdl/pmrm_register_map.sv
// Management register map and address decode for the two integrated PHYs.
`timescale 1ns/1ns
module pmrm_register_map
	import pmrm_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input pmrm_mgmt_req_t mgmt_req,
	output pmrm_mgmt_rsp_t mgmt_rsp,
	input pmrm_serial_req_t ser_req,
	output logic [7:0] ser_rdata,
	input wire logic [15:0] phy1_status,
	input wire logic [15:0] phy1_id_high,
	input wire logic [15:0] phy1_id_low,
	input wire logic [15:0] phy1_advert,
	input wire logic [15:0] phy1_partner,
	input wire logic [15:0] phy1_special,
	input wire logic [15:0] phy2_status,
	input wire logic [15:0] phy2_id_high,
	input wire logic [15:0] phy2_id_low,
	input wire logic [15:0] phy2_advert,
	input wire logic [15:0] phy2_partner,
	input wire logic [15:0] phy2_special,
	input wire logic [15:0] phy2_cable_diag,
	output logic [15:0] ext_wdata,
	output logic [1:0] ext_we_advert,
	output logic [1:0] ext_we_special,
	output logic ext_we_cable_diag,
	output pmrm_phy_ctrl_t phy1_ctrl,
	output pmrm_phy_ctrl_t phy2_ctrl,
	output logic [1:0] autoneg_restart,
	output logic port2_loop_via_phy1,
	output logic port1_loop_via_phy2
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [4:0] phy_addr;
		logic [7:0] global_ctrl;
		logic addr_programmed;
		pmrm_mgmt_rsp_t rsp;
		logic [7:0] ser_rdata;
		logic [15:0] ext_wdata;
		logic [1:0] we_advert;
		logic [1:0] we_special;
		logic we_cable;
		logic [1:0] redo_q;
	} pmrm_map_state_t;

	pmrm_map_state_t state;
	pmrm_map_state_t next_state;

	logic [4:0] phy_addr_of [2];
	logic [1:0] hit;
	logic [1:0] ctrl_we;
	logic [1:0] ser_we_loop;
	logic [1:0] ser_we_an;
	logic [1:0] ser_we_xo;
	logic [15:0] ctrl_word [2];
	pmrm_phy_ctrl_t ctrl [2];
	logic reg_ok;
	logic [15:0] sel_word;

	// Each PHY answers on its default address until the global field is
	// written; PHY2 then takes the address after PHY1's.
	assign phy_addr_of[0] = state.addr_programmed ? state.phy_addr
		: PMRM_PHY1_ADDR_RST;
	assign phy_addr_of[1] = state.addr_programmed
		? 5'(state.phy_addr + 5'h01) : PMRM_PHY2_ADDR_RST;

	// ---------------------------------------------------------------
	// Per-PHY control
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_phy
			assign hit[g] = mgmt_req.req && mgmt_req.phy_addr == phy_addr_of[g];
			assign ctrl_we[g] = hit[g] && mgmt_req.write
				&& mgmt_req.reg_addr == PMRM_REG_CONTROL;
			assign ser_we_loop[g] = ser_req.req && ser_req.write
				&& ser_req.addr == (g == 0 ? PMRM_LOOP1_ADDR : PMRM_LOOP2_ADDR);
			assign ser_we_an[g] = ser_req.req && ser_req.write
				&& ser_req.addr == (g == 0 ? PMRM_AN1_ADDR : PMRM_AN2_ADDR);
			assign ser_we_xo[g] = ser_req.req && ser_req.write
				&& ser_req.addr == (g == 0 ? PMRM_XO1_ADDR : PMRM_XO2_ADDR);
			pmrm_phy_ctrl u_ctrl (
				.ref_clk(ref_clk),
				.resetn(resetn),
				.mgmt_we(ctrl_we[g]),
				.mgmt_wdata(mgmt_req.wdata),
				.ser_we_loop(ser_we_loop[g]),
				.ser_we_an(ser_we_an[g]),
				.ser_we_xo(ser_we_xo[g]),
				.ser_wdata(ser_req.wdata),
				.ctrl(ctrl[g]),
				.ctrl_word(ctrl_word[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Management read decode
	// ---------------------------------------------------------------
	always_comb
	begin
		reg_ok = 1'b1;
		sel_word = 16'h0000;
		case (mgmt_req.reg_addr)
			PMRM_REG_CONTROL:
				sel_word = hit[1] ? ctrl_word[1] : ctrl_word[0];
			PMRM_REG_STATUS:
				sel_word = hit[1] ? phy2_status : phy1_status;
			PMRM_REG_ID_HIGH:
				sel_word = hit[1] ? phy2_id_high : phy1_id_high;
			PMRM_REG_ID_LOW:
				sel_word = hit[1] ? phy2_id_low : phy1_id_low;
			PMRM_REG_ADVERT:
				sel_word = hit[1] ? phy2_advert : phy1_advert;
			PMRM_REG_PARTNER:
				sel_word = hit[1] ? phy2_partner : phy1_partner;
			// Cable diagnostics exist only behind the second PHY.
			PMRM_REG_CABLE_DIAG:
			begin
				reg_ok = hit[1];
				sel_word = hit[1] ? phy2_cable_diag : 16'h0000;
			end
			PMRM_REG_SPECIAL:
				sel_word = hit[1] ? phy2_special : phy1_special;
			default:
				reg_ok = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.rsp.ack = mgmt_req.req;
		next_state.rsp.supported = (|hit) && reg_ok;
		next_state.we_advert = 2'b00;
		next_state.we_special = 2'b00;
		next_state.we_cable = 1'b0;
		if ((|hit) && reg_ok && !mgmt_req.write)
			next_state.rsp.rdata = sel_word;
		else if (mgmt_req.req && !mgmt_req.write)
			next_state.rsp.rdata = 16'h0000;
		if ((|hit) && reg_ok && mgmt_req.write)
		begin
			next_state.ext_wdata = mgmt_req.wdata;
			next_state.we_advert = {2{mgmt_req.reg_addr == PMRM_REG_ADVERT}}
				& hit;
			next_state.we_special = {2{mgmt_req.reg_addr == PMRM_REG_SPECIAL}}
				& hit;
			next_state.we_cable = mgmt_req.reg_addr == PMRM_REG_CABLE_DIAG;
		end
		if (ser_req.req && ser_req.write
			&& ser_req.addr == PMRM_GLOBAL_CTRL_ADDR)
		begin
			next_state.global_ctrl = ser_req.wdata;
			next_state.phy_addr =
				ser_req.wdata[PMRM_GADDR_MSB:PMRM_GADDR_LSB];
			next_state.addr_programmed = 1'b1;
		end
		next_state.ser_rdata = 8'h00;
		if (ser_req.req && !ser_req.write)
		begin
			case (ser_req.addr)
				PMRM_GLOBAL_CTRL_ADDR: next_state.ser_rdata = state.global_ctrl;
				PMRM_LOOP1_ADDR: next_state.ser_rdata = {2'b00,
					ctrl[0].autoneg_redo, 1'b0, ctrl[0].power_down, 1'b0,
					ctrl[0].force_straight_pairing, ctrl[0].loopback};
				PMRM_LOOP2_ADDR: next_state.ser_rdata = {2'b00,
					ctrl[1].autoneg_redo, 1'b0, ctrl[1].power_down, 1'b0,
					ctrl[1].force_straight_pairing, ctrl[1].loopback};
				PMRM_AN1_ADDR: next_state.ser_rdata = {ctrl[0].autoneg_on,
					ctrl[0].speed100, ctrl[0].full_duplex, 5'h00};
				PMRM_AN2_ADDR: next_state.ser_rdata = {ctrl[1].autoneg_on,
					ctrl[1].speed100, ctrl[1].full_duplex, 5'h00};
				PMRM_XO1_ADDR:
					next_state.ser_rdata = {ctrl[0].crossover_style_select, 7'h00};
				PMRM_XO2_ADDR:
					next_state.ser_rdata = {ctrl[1].crossover_style_select, 7'h00};
				default: next_state.ser_rdata = 8'h00;
			endcase
		end
		next_state.redo_q = {ctrl[1].autoneg_redo, ctrl[0].autoneg_redo};
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			state <= '0;
		else
			state <= next_state;
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign mgmt_rsp = state.rsp;
	assign ser_rdata = state.ser_rdata;
	assign ext_wdata = state.ext_wdata;
	assign ext_we_advert = state.we_advert;
	assign ext_we_special = state.we_special;
	assign ext_we_cable_diag = state.we_cable;
	assign phy1_ctrl = ctrl[0];
	assign phy2_ctrl = ctrl[1];
	// A restart is a rising edge on the redo bit, so holding it at 1 does
	// not retrigger negotiation every cycle.
	assign autoneg_restart = {ctrl[1].autoneg_redo, ctrl[0].autoneg_redo}
		& ~state.redo_q;
	assign port2_loop_via_phy1 = ctrl[0].loopback;
	assign port1_loop_via_phy2 = ctrl[1].loopback;

endmodule // pmrm_register_map

//--- testbench/pmrm_mgmt_station.sv
// Management station model issuing one register access at a time.
`timescale 1ns/1ns
module pmrm_mgmt_station
	import pmrm_pkg::*;
(
	input wire logic ref_clk,
	output pmrm_mgmt_req_t mgmt_req,
	input pmrm_mgmt_rsp_t mgmt_rsp
);
	initial mgmt_req = '0;
	task automatic access(input logic wr, input logic [4:0] phy,
		input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd, output logic ok);
		@(posedge ref_clk);
		#1;
		mgmt_req = '{1'b1, wr, phy, ra, wd};
		@(posedge ref_clk);
		#1;
		// Released fields are inverted so stale values can never match.
		mgmt_req = '{1'b0, ~wr, ~phy, ~ra, ~wd};
		rd = mgmt_rsp.rdata;
		ok = mgmt_rsp.ack && mgmt_rsp.supported;
	endtask
endmodule // pmrm_mgmt_station

//--- testbench/pmrm_register_map_props.sv
// Concurrent checks on the ports of the PHY management register map.
`timescale 1ns/1ns
module pmrm_register_map_props
	import pmrm_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input pmrm_mgmt_req_t mgmt_req,
	input pmrm_mgmt_rsp_t mgmt_rsp,
	input pmrm_serial_req_t ser_req,
	input pmrm_phy_ctrl_t phy1_ctrl,
	input pmrm_phy_ctrl_t phy2_ctrl,
	input wire logic [1:0] autoneg_restart,
	input wire logic port2_loop_via_phy1,
	input wire logic port1_loop_via_phy2
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	logic bad_reg;
	assign bad_reg = mgmt_req.reg_addr inside {[5'h06:5'h1C], 5'h1E};
	sequence s_take;
		mgmt_req.req;
	endsequence
	// Control word write that the map accepted; serial writes excluded.
	sequence s_ctrl_wr;
		mgmt_req.req && mgmt_req.write && mgmt_req.reg_addr == 5'h00
			&& !ser_req.req ##1 mgmt_rsp.supported;
	endsequence
	property p_ack;
		s_take |=> mgmt_rsp.ack;
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack missing after request");
	property p_no_ack;
		!mgmt_req.req |=> !mgmt_rsp.ack;
	endproperty
	a_no_ack: assert property (p_no_ack)
		else $error("ack without request");
	// A refused write keeps the last read data; a refused read returns 0.
	property p_unsup;
		s_take ##0 bad_reg |=> mgmt_rsp.ack && !mgmt_rsp.supported
			&& ($past(mgmt_req.write) || mgmt_rsp.rdata == 16'h0000);
	endproperty
	a_unsup: assert property (p_unsup)
		else $error("unsupported reg answered");
	property p_loop1;
		ser_req.req && ser_req.write && ser_req.addr == 8'h1D
			|=> port2_loop_via_phy1 == $past(ser_req.wdata[0]);
	endproperty
	a_loop1: assert property (p_loop1)
		else $error("port 2 loop route wrong");
	property p_loop2;
		ser_req.req && ser_req.write && ser_req.addr == 8'h2D
			|=> port1_loop_via_phy2 == $past(ser_req.wdata[0]);
	endproperty
	a_loop2: assert property (p_loop2)
		else $error("port 1 loop route wrong");
	property p_ctrl_wr;
		s_ctrl_wr |-> (phy1_ctrl.loopback == $past(mgmt_req.wdata[14])
			&& phy1_ctrl.speed100 == $past(mgmt_req.wdata[13]))
			|| (phy2_ctrl.loopback == $past(mgmt_req.wdata[14])
			&& phy2_ctrl.speed100 == $past(mgmt_req.wdata[13]));
	endproperty
	a_ctrl_wr: assert property (p_ctrl_wr)
		else $error("control write lost");
	property p_restart;
		$rose(phy1_ctrl.autoneg_redo) |-> ##[0:1] autoneg_restart[0];
	endproperty
	a_restart: assert property (p_restart)
		else $error("no restart pulse");
	property p_rstval;
		$rose(resetn) |-> phy1_ctrl == 8'h22 && phy2_ctrl == 8'h22;
	endproperty
	a_rstval: assert property (p_rstval)
		else $error("control reset value");
endmodule // pmrm_register_map_props

bind pmrm_register_map pmrm_register_map_props i_pmrm_register_map_props (
	.ref_clk(ref_clk), .resetn(resetn), .mgmt_req(mgmt_req),
	.mgmt_rsp(mgmt_rsp), .ser_req(ser_req), .phy1_ctrl(phy1_ctrl),
	.phy2_ctrl(phy2_ctrl), .autoneg_restart(autoneg_restart),
	.port2_loop_via_phy1(port2_loop_via_phy1),
	.port1_loop_via_phy2(port1_loop_via_phy2));

//--- testbench/pmrm_register_map_tb_top.sv
// Self-checking testbench for the PHY management register map.
`timescale 1ns/1ns
module pmrm_register_map_tb_top
	import pmrm_pkg::*;
;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	pmrm_mgmt_req_t mgmt_req;
	pmrm_mgmt_rsp_t mgmt_rsp;
	pmrm_serial_req_t ser_req = '0;
	pmrm_phy_ctrl_t phy1_ctrl, phy2_ctrl;
	logic [15:0] ro_in [13];
	logic [1:0] autoneg_restart;
	logic loop2, loop1;
	logic [7:0] ser_rdata;
	logic [15:0] ext_wdata;
	logic [1:0] ext_we_advert;
	logic [1:0] ext_we_special;
	logic ext_we_cable_diag;
	int err_count = 0;
	int tests_run = 0;
	int pulses = 0;
	int pulses2 = 0;
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (autoneg_restart[0] === 1'b1) pulses++;
	always @(posedge ref_clk) if (autoneg_restart[1] === 1'b1) pulses2++;
	pmrm_mgmt_station i_pmrm_mgmt_station (.ref_clk(ref_clk),
		.mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp));
	pmrm_register_map i_pmrm_register_map (.ref_clk(ref_clk),
		.resetn(resetn), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp),
		.ser_req(ser_req), .ser_rdata(ser_rdata), .phy1_status(ro_in[0]),
		.phy1_id_high(ro_in[1]), .phy1_id_low(ro_in[2]),
		.phy1_advert(ro_in[3]), .phy1_partner(ro_in[4]),
		.phy1_special(ro_in[5]), .phy2_status(ro_in[6]),
		.phy2_id_high(ro_in[7]), .phy2_id_low(ro_in[8]),
		.phy2_advert(ro_in[9]), .phy2_partner(ro_in[10]),
		.phy2_special(ro_in[11]), .phy2_cable_diag(ro_in[12]),
		.ext_wdata(ext_wdata), .ext_we_advert(ext_we_advert),
		.ext_we_special(ext_we_special),
		.ext_we_cable_diag(ext_we_cable_diag),
		.phy1_ctrl(phy1_ctrl), .phy2_ctrl(phy2_ctrl),
		.autoneg_restart(autoneg_restart), .port2_loop_via_phy1(loop2),
		.port1_loop_via_phy2(loop1));
	task automatic chk16(input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("mismatch at %0t exp %h got %h", $time, exp, got);
			err_count++;
		end
	endtask
	task automatic rd(input logic [4:0] p, input logic [4:0] r,
		input logic [15:0] exp, input logic exp_ok);
		logic [15:0] d;
		logic ok;
		i_pmrm_mgmt_station.access(1'b0, p, r, 16'h0000, d, ok);
		chk16(exp, d);
		chk16({15'h0000, exp_ok}, {15'h0000, ok});
	endtask
	task automatic wr(input logic [4:0] p, input logic [15:0] v);
		logic [15:0] d;
		logic ok;
		i_pmrm_mgmt_station.access(1'b1, p, 5'h00, v, d, ok);
	endtask
	task automatic ser_wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		#1;
		ser_req = '{1'b1, 1'b1, a, v};
		@(posedge ref_clk);
		#1;
		ser_req = '{1'b0, 1'b0, ~a, ~v};
	endtask
	// Read data stands for one cycle after the request edge.
	task automatic ser_rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		#1;
		ser_req = '{1'b1, 1'b0, a, 8'h00};
		@(posedge ref_clk);
		#1;
		ser_req = '{1'b0, 1'b1, ~a, 8'hFF};
		chk16({8'h00, exp}, {8'h00, ser_rdata});
	endtask
	task automatic final_report();
		$display("tests_run %0d err_count %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic t_reset_values();
		rd(5'h01, 5'h00, 16'h1020, 1'b1);
		rd(5'h02, 5'h00, 16'h1020, 1'b1);
		$display("test reset_values done");
	endtask
	task automatic t_loopback();
		wr(5'h01, 16'h5020);
		chk16(16'h0002, {14'h0000, loop2, loop1});
		rd(5'h01, 5'h00, 16'h5020, 1'b1);
		wr(5'h02, 16'h5020);
		chk16(16'h0003, {14'h0000, loop2, loop1});
		wr(5'h01, 16'h1020);
		wr(5'h02, 16'h1020);
		chk16(16'h0000, {14'h0000, loop2, loop1});
		$display("test loopback done");
	endtask
	task automatic t_fixed_bits();
		int n;
		n = pulses;
		wr(5'h01, 16'hFFFF);
		rd(5'h01, 5'h00, 16'h7B30, 1'b1);
		chk16(16'(n + 1), 16'(pulses));
		chk16(16'h00FF, {8'h00, phy1_ctrl});
		wr(5'h01, 16'h1020);
		n = pulses2;
		wr(5'h02, 16'h1220);
		rd(5'h02, 5'h00, 16'h1220, 1'b1);
		chk16(16'(n + 1), 16'(pulses2));
		wr(5'h02, 16'h1020);
		$display("test fixed_bits done");
	endtask
	task automatic t_reg_table();
		logic [4:0] bad [3] = '{5'h06, 5'h1C, 5'h1E};
		for (int p = 0; p < 2; p++)
			for (int r = 1; r < 6; r++)
				rd(5'(p + 1), 5'(r), ro_in[p * 6 + r - 1], 1'b1);
		rd(5'h01, 5'h1F, ro_in[5], 1'b1);
		rd(5'h02, 5'h1F, ro_in[11], 1'b1);
		rd(5'h02, 5'h1D, ro_in[12], 1'b1);
		rd(5'h01, 5'h1D, 16'h0000, 1'b0);
		foreach (bad[i])
		begin
			rd(5'h01, bad[i], 16'h0000, 1'b0);
			rd(5'h02, bad[i], 16'h0000, 1'b0);
		end
		$display("test reg_table done");
	endtask
	task automatic t_serial_mirror();
		ser_wr(8'h1D, 8'h03);
		rd(5'h01, 5'h00, 16'h5030, 1'b1);
		chk16(16'h0001, {15'h0000, loop2});
		ser_rd(8'h1D, 8'h03);
		ser_wr(8'h1D, 8'h00);
		rd(5'h01, 5'h00, 16'h1020, 1'b1);
		ser_wr(8'h2D, 8'h01);
		chk16(16'h0001, {15'h0000, loop1});
		ser_rd(8'h2D, 8'h01);
		ser_wr(8'h2D, 8'h00);
		ser_wr(8'h1C, 8'h60);
		rd(5'h01, 5'h00, 16'h2120, 1'b1);
		ser_rd(8'h1C, 8'h60);
		ser_wr(8'h1C, 8'h80);
		ser_wr(8'h2F, 8'h00);
		rd(5'h02, 5'h00, 16'h1000, 1'b1);
		ser_rd(8'h2F, 8'h00);
		ser_wr(8'h2F, 8'h80);
		ser_rd(8'h0F, 8'h00);
		ser_rd(8'h30, 8'h00);
		$display("test serial_mirror done");
	endtask
	task automatic t_ext_writes();
		logic [15:0] d;
		logic ok;
		i_pmrm_mgmt_station.access(1'b1, 5'h02, 5'h04, 16'h1234, d, ok);
		chk16(16'h1234, ext_wdata);
		chk16(16'h0002, {14'h0000, ext_we_advert});
		i_pmrm_mgmt_station.access(1'b1, 5'h01, 5'h1F, 16'h5678, d, ok);
		chk16(16'h0001, {14'h0000, ext_we_special});
		chk16(16'h0000, {14'h0000, ext_we_advert});
		i_pmrm_mgmt_station.access(1'b1, 5'h02, 5'h1D, 16'h9ABC, d, ok);
		chk16(16'h0001, {15'h0000, ext_we_cable_diag});
		chk16(16'h9ABC, ext_wdata);
		i_pmrm_mgmt_station.access(1'b1, 5'h01, 5'h1D, 16'hDEF0, d, ok);
		chk16(16'h0000, {15'h0000, ext_we_cable_diag});
		chk16(16'h9ABC, ext_wdata);
		chk16(16'h0000, {15'h0000, ok});
		$display("test ext_writes done");
	endtask
	task automatic t_phy_address();
		rd(5'h00, 5'h00, 16'h0000, 1'b0);
		rd(5'h03, 5'h00, 16'h0000, 1'b0);
		ser_wr(8'h0F, 8'h28);
		ser_rd(8'h0F, 8'h28);
		rd(5'h05, 5'h00, 16'h1020, 1'b1);
		rd(5'h06, 5'h00, 16'h1020, 1'b1);
		rd(5'h01, 5'h00, 16'h0000, 1'b0);
		// A second reset must bring the default addresses back.
		resetn = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		rd(5'h01, 5'h00, 16'h1020, 1'b1);
		$display("test phy_address done");
	endtask
	initial
	begin
		foreach (ro_in[i])
			ro_in[i] = 16'hA000 | 16'(i * 16'h0111);
		repeat (3) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		t_reset_values();
		t_loopback();
		t_fixed_bits();
		t_reg_table();
		t_serial_mirror();
		t_ext_writes();
		t_phy_address();
		final_report();
	end
	initial
	begin
		#(100 * 3000);
		err_count++;
		final_report();
	end
endmodule // pmrm_register_map_tb_top
